// *** core/dcfg_regs.sv ***
// dac configuration register bank with decoded control outputs
`timescale 1ns/100ps
// What this block does
// - state register fields and reset value 0x922
// - mux bit selects 4:1 or 2:1
// - two-bit waveform mode selection
// - under-clock codes give full, half, quarter rate
// - source bit picks pins or clock register
// - pulse begin code maps to setting
// - pulse begin only outside nrz mode
// - pulse width only in narrow and rf
// - defaults on reset or reset pin with load
// - ten-bit gain register resets to 0x200
// - clock register fields, reset value 0x080
// - bit zero is divide select
// - three-bit phase pins, single divide pin
// - sixteen bits, address then data, msb first
// - early load release aborts the write
// - extra bits and extra clocks ignored
module dcfg_regs
  import dcfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic load_n,
  input wire logic sdata,
  input wire logic reg_rst_n,
  input wire logic [2:0] phase_shift_pin,
  input wire logic clock_divide_pin,
  output logic mux_two_to_one,
  output dcfg_pkg::dcfg_wave_t wave_mode,
  output logic [2:0] mux_rate_div,
  output logic [2:0] pulse_begin_setting,
  output logic pulse_begin_active,
  output logic [2:0] pulse_width_setting,
  output logic pulse_width_active,
  output logic [9:0] gain_code,
  output logic clock_divide_sel,
  output logic [2:0] phase_shift_sel,
  output logic [2:0] aux_delay_field
);
  import dcfg_pkg::*;

  // pins are asynchronous to ref_clk: two stages each
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic [11:0] state_config_q;
  logic [11:0] gain_adjust_q;
  logic [11:0] output_clock_config_q;
  logic reg_rst;
  dcfg_word_if word ();

  // reset to the idle pin levels so no false sclk edge or pin reset follows reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= 9'h014;
      sync2_q <= 9'h014;
    end else begin
      sync1_q <= {clock_divide_pin, phase_shift_pin, reg_rst_n, sdata, load_n, sclk, 1'b0};
      sync2_q <= sync1_q;
    end
  end

  dcfg_serial_rx u_rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclk_s(sync2_q[1]),
    .load_n_s(sync2_q[2]),
    .sdata_s(sync2_q[3]),
    .word(word)
  );

  // the register reset only acts together with a low load enable
  assign reg_rst = !sync2_q[4] && !sync2_q[2];

  // shared by begin and width fields: codes 000,001,100,111 all give setting 2
  function automatic logic [2:0] dcfg_pulse_map(input logic [2:0] code);
    case (code)
      3'h2: dcfg_pulse_map = 3'h0;
      3'h3: dcfg_pulse_map = 3'h1;
      3'h5: dcfg_pulse_map = 3'h3;
      3'h6: dcfg_pulse_map = 3'h4;
      default: dcfg_pulse_map = 3'h2;
    endcase
  endfunction : dcfg_pulse_map

  always_ff @(posedge ref_clk) begin
    if (rst || reg_rst) begin
      state_config_q <= DCFG_RST_STATE;
      gain_adjust_q <= DCFG_RST_GAIN;
      output_clock_config_q <= DCFG_RST_OCLK;
    end else if (word.strobe) begin
      // unmapped addresses fall through untouched
      case (word.addr)
        DCFG_ADDR_STATE: state_config_q <= word.data;
        DCFG_ADDR_GAIN: gain_adjust_q <= {2'h0, word.data[9:0]};
        DCFG_ADDR_OCLK: output_clock_config_q <= {4'h0, word.data[7:0]};
        default: ;
      endcase
    end
  end

  logic [2:0] wave_bits;
  logic [1:0] uclk;
  assign wave_bits = {1'b0, state_config_q[DCFG_MODE_POS +: 2]};
  assign uclk = state_config_q[DCFG_UCLK_POS +: 2];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mux_two_to_one <= 1'b0;
      wave_mode <= DCFG_WAVE_NARROW_RETURN_ZERO;
      mux_rate_div <= 3'h1;
      pulse_begin_setting <= 3'h2;
      pulse_begin_active <= 1'b1;
      pulse_width_setting <= 3'h2;
      pulse_width_active <= 1'b1;
      gain_code <= 10'h200;
      clock_divide_sel <= 1'b0;
      phase_shift_sel <= 3'h0;
      aux_delay_field <= 3'h4;
    end else begin
      mux_two_to_one <= state_config_q[DCFG_MUX_POS];
      wave_mode <= dcfg_wave_t'(wave_bits[1:0]);
      case (uclk)
        2'h2: mux_rate_div <= 3'h2;
        2'h3: mux_rate_div <= 3'h4;
        default: mux_rate_div <= 3'h1;
      endcase
      pulse_begin_setting <= dcfg_pulse_map(state_config_q[DCFG_PB_POS +: 3]);
      pulse_begin_active <= wave_bits[1:0] != DCFG_WAVE_NRZ;
      pulse_width_setting <= dcfg_pulse_map(state_config_q[DCFG_PW_POS +: 3]);
      pulse_width_active <= (wave_bits[1:0] == DCFG_WAVE_NARROW_RETURN_ZERO) ||
                            (wave_bits[1:0] == DCFG_WAVE_RF);
      gain_code <= gain_adjust_q[DCFG_GAIN_BITS-1:0];
      aux_delay_field <= output_clock_config_q[DCFG_AUX_POS +: 3];
      if (state_config_q[DCFG_SRC_POS]) begin
        clock_divide_sel <= sync2_q[8];
        phase_shift_sel <= sync2_q[7:5];
      end else begin
        clock_divide_sel <= output_clock_config_q[DCFG_DIV_POS];
        phase_shift_sel <= output_clock_config_q[DCFG_PSS_POS +: 3];
      end
    end
  end
endmodule : dcfg_regs

// *** core/dcfg_pkg.sv ***
// constants for the dac configuration register bank
package dcfg_pkg;
  localparam logic [3:0] DCFG_ADDR_STATE = 4'h0;
  localparam logic [3:0] DCFG_ADDR_GAIN = 4'h1;
  localparam logic [3:0] DCFG_ADDR_OCLK = 4'h5;
  localparam logic [11:0] DCFG_RST_STATE = 12'h922;
  localparam logic [11:0] DCFG_RST_GAIN = 12'h200;
  localparam logic [11:0] DCFG_RST_OCLK = 12'h080;
  localparam int DCFG_ADDR_BITS = 4;
  localparam int DCFG_DATA_BITS = 12;
  localparam logic [4:0] DCFG_FRAME_BITS = 5'h10;
  localparam int DCFG_MUX_POS = 0;
  localparam int DCFG_MODE_POS = 1;
  localparam int DCFG_UCLK_POS = 3;
  localparam int DCFG_SRC_POS = 5;
  localparam int DCFG_PB_POS = 6;
  localparam int DCFG_PW_POS = 9;
  localparam int DCFG_GAIN_BITS = 10;
  localparam int DCFG_DIV_POS = 0;
  localparam int DCFG_PSS_POS = 2;
  localparam int DCFG_AUX_POS = 5;
  typedef enum logic [1:0] {
    DCFG_WAVE_NRZ = 2'h0,
    DCFG_WAVE_NARROW_RETURN_ZERO = 2'h1,
    DCFG_WAVE_RTZ = 2'h2,
    DCFG_WAVE_RF = 2'h3
  } dcfg_wave_t;
endpackage : dcfg_pkg

// *** core/dcfg_word_if.sv ***
// interface carrying one assembled serial write word
`timescale 1ns/100ps
interface dcfg_word_if;
  logic strobe;
  logic [3:0] addr;
  logic [11:0] data;
  modport src (output strobe, output addr, output data);
  modport dst (input strobe, input addr, input data);
endinterface : dcfg_word_if

// *** core/dcfg_serial_rx.sv ***
// three-wire serial write receiver, sampled in the ref_clk domain
`timescale 1ns/100ps
module dcfg_serial_rx
  import dcfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk_s,
  input wire logic load_n_s,
  input wire logic sdata_s,
  dcfg_word_if.src word
);
  logic sclk_prev_q;
  logic [4:0] cnt_q;
  logic [15:0] shift_q;
  logic done_q;
  logic rise;
  assign rise = sclk_s & ~sclk_prev_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // a high load enable aborts a partial frame, nothing is written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (rise) begin
      if (load_n_s) begin
        cnt_q <= 5'h00;
        done_q <= 1'b0;
      end else if (!done_q) begin
        shift_q <= {shift_q[14:0], sdata_s};
        cnt_q <= cnt_q + 5'h01;
        done_q <= (cnt_q + 5'h01) == DCFG_FRAME_BITS;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word.strobe <= 1'b0;
      word.addr <= 4'h0;
      word.data <= 12'h000;
    end else begin
      word.strobe <= rise && !load_n_s && !done_q && (cnt_q == DCFG_FRAME_BITS - 5'h01);
      word.addr <= shift_q[14:11];
      word.data <= {shift_q[10:0], sdata_s};
    end
  end
endmodule : dcfg_serial_rx

// *** verification/dcfg_host_model.sv ***
// serial configuration host for the three-wire write port
`timescale 1ns/100ps
module dcfg_host_model (
  input wire logic ref_clk,
  output logic sclk,
  output logic load_n,
  output logic sdata
);
  initial begin
    sclk = 1'b0;
    load_n = 1'b1;
    sdata = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : hw
  // n frame bits, x extra clocks, then one clock with load high to rearm
  task automatic send(input logic [15:0] w, input int n, input int x);
    load_n = 1'b0;
    hw(50);
    for (int i = 0; i < n + x; i++) begin
      sdata = (i < 16) ? w[15 - i] : ~sdata;
      hw(5);
      sclk = 1'b1;
      hw(5);
      sclk = 1'b0;
    end
    hw(20);
    load_n = 1'b1;
    sdata = ~sdata;
    hw(50);
    sclk = 1'b1;
    hw(5);
    sclk = 1'b0;
    hw(10);
  endtask : send
endmodule : dcfg_host_model

// *** verification/dcfg_regs_properties.sv ***
// output checks for the configuration bank
`timescale 1ns/100ps
module dcfg_regs_properties
  import dcfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load_n,
  input wire dcfg_pkg::dcfg_wave_t wave_mode,
  input wire logic [2:0] mux_rate_div,
  input wire logic [2:0] pulse_begin_setting,
  input wire logic pulse_begin_active,
  input wire logic pulse_width_active,
  input wire logic [9:0] gain_code
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pb_gate: assert property (pulse_begin_active == (wave_mode != DCFG_WAVE_NRZ))
    else $error("pulse begin gate wrong");
  a_pw_gate: assert property (pulse_width_active == wave_mode[0])
    else $error("pulse width gate wrong");
  a_rate_legal: assert property (mux_rate_div inside {3'h1, 3'h2, 3'h4})
    else $error("rate code illegal");
  a_pb_range: assert property (pulse_begin_setting <= 3'h4)
    else $error("pulse begin out of range");
  a_rst_state: assert property ($fell(rst) |-> wave_mode == DCFG_WAVE_NARROW_RETURN_ZERO)
    else $error("state default wrong");
  a_rst_gain: assert property ($fell(rst) |-> gain_code == 10'h200)
    else $error("gain default wrong");
  a_quiet_gain: assert property (load_n [*8] |-> $stable(gain_code))
    else $error("gain moved while idle");
  a_quiet_mode: assert property (load_n [*8] |-> $stable(wave_mode))
    else $error("mode moved while idle");
  c_rf: cover property (wave_mode == DCFG_WAVE_RF);
  c_quarter: cover property (mux_rate_div == 3'h4);
  c_gain_max: cover property (gain_code == 10'h3FF);
endmodule : dcfg_regs_properties
bind dcfg_regs dcfg_regs_properties dcfg_regs_properties_i (.ref_clk(ref_clk), .rst(rst),
  .load_n(load_n), .wave_mode(wave_mode), .mux_rate_div(mux_rate_div),
  .pulse_begin_setting(pulse_begin_setting), .pulse_begin_active(pulse_begin_active),
  .pulse_width_active(pulse_width_active), .gain_code(gain_code));

// *** verification/testbench.sv ***
// self-checking bench for the configuration bank
`timescale 1ns/100ps
module testbench;
  import dcfg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rrn = 1'b1;
  logic sclk, load_n, sdata, mux, pba, pwa, dv;
  dcfg_wave_t md;
  logic [2:0] rt, pb, pw, ps, ax;
  logic [2:0] pss_pin = 3'h6;
  logic div_pin = 1'b1;
  logic [9:0] g;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  dcfg_host_model dcfg_host_model_i (.ref_clk(ref_clk), .sclk(sclk), .load_n(load_n),
    .sdata(sdata));
  dcfg_regs dcfg_regs_i (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .load_n(load_n),
    .sdata(sdata), .reg_rst_n(rrn), .phase_shift_pin(pss_pin), .clock_divide_pin(div_pin),
    .mux_two_to_one(mux), .wave_mode(md), .mux_rate_div(rt), .pulse_begin_setting(pb),
    .pulse_begin_active(pba), .pulse_width_setting(pw), .pulse_width_active(pwa),
    .gain_code(g), .clock_divide_sel(dv), .phase_shift_sel(ps), .aux_delay_field(ax));
  task automatic chk(input string s, input logic [11:0] v, input logic [11:0] e);
    cmp_count++;
    if (v !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [11:0] d, input int n = 16, int x = 0);
    dcfg_host_model_i.send({a, d}, n, x);
  endtask : wr
  task automatic t_fields;
    logic [2:0] tb_map [8] = '{3'h2, 3'h2, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h2};
    logic [2:0] tb_rate [4] = '{3'h1, 3'h1, 3'h2, 3'h4};
    chk("dflt", {md, rt, pb, pw, g == 10'h200}, 12'h4A5);
    chk("dmux", {mux, pba, pwa, dv, ps}, 12'h03E);
    for (int i = 0; i < 8; i++) begin
      wr(DCFG_ADDR_STATE, {i[2:0], i[2:0], 1'b1, i[1:0], i[1:0], i[0]});
      chk("st", {mux, md, rt, pb, pw}, {i[0], i[1:0], tb_rate[i[1:0]], tb_map[i], tb_map[i]});
      chk("act", {pba, pwa, dv, ps}, {i[1:0] != 2'h0, i[0], 4'hE});
    end
    $display("fields done");
  endtask : t_fields
  task automatic t_clock;
    wr(DCFG_ADDR_STATE, 12'h902);
    chk("oclk", {dv, ps}, 12'h0);
    wr(DCFG_ADDR_OCLK, 12'h081);
    chk("div", {dv, ps}, 12'h8);
    wr(DCFG_ADDR_OCLK, 12'h09C);
    chk("pss", {dv, ps}, 12'h7);
    chk("aux", ax, 12'h4);
    wr(DCFG_ADDR_STATE, 12'h926);
    chk("pins", {dv, ps}, 12'hE);
    pss_pin = 3'h1;
    div_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("pinlsb", {dv, ps}, 12'h1);
    $display("clock done");
  endtask : t_clock
  task automatic t_refused;
    wr(DCFG_ADDR_GAIN, 12'hFFF);
    chk("gmax", g, 12'h3FF);
    wr(DCFG_ADDR_GAIN, 12'h000, 10);
    chk("abort", g, 12'h3FF);
    wr(DCFG_ADDR_GAIN, 12'h000, 16, 6);
    chk("extra", g, 12'h000);
    for (int a = 2; a < 16; a++) if (a != 5) wr(a[3:0], 12'h155);
    chk("unmap", {md, g}, 12'hC00);
    rrn = 1'b0;
    wr(4'hF, 12'h000);
    rrn = 1'b1;
    chk("rrst", {md, g}, 12'h600);
    wr(DCFG_ADDR_GAIN, 12'h123);
    chk("g123", g, 12'h123);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("prst", {md, g}, 12'h600);
    $display("refused done");
  endtask : t_refused
  initial begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_fields();
    t_clock();
    t_refused();
    report_and_stop();
  end
endmodule : testbench
